// [budget_regs.svh]
/*
  Register map, field positions, reset values and error codes of the
  port power budget manager. Assumes a 32-bit AXI4-Lite bus, one word per register.
*/
`ifndef BUDGET_REGS_SVH
`define BUDGET_REGS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define OFF_CMD       8'h00
`define OFF_ARG       8'h04
`define OFF_RESULT    8'h08
`define OFF_REMAIN    8'h0C
`define OFF_GRANTED   8'h10
`define OFF_CONSUMED  8'h14
`define OFF_PROVIDED  8'h18
`define OFF_SETTINGS  8'h1C
`define OFF_ON_LO     8'h20
`define OFF_ON_HI     8'h24

// ---------------------------------------------------------------
// command word fields
// ---------------------------------------------------------------
`define CMD_OP_MSB    3
`define CMD_OP_LSB    0
`define CMD_IX_MSB    13
`define CMD_IX_LSB    8

// ---------------------------------------------------------------
// sizes and limits
// ---------------------------------------------------------------
`define NUM_PORTS     6'h30
`define NUM_SUPPLIES  6'h03
`define PCT_FULL      8'h64
`define PRIO_TOP      2'h3

// ---------------------------------------------------------------
// factory defaults
// ---------------------------------------------------------------
`define DEF_CAPACITY  32'h0000_0000
`define DEF_RESERVE   8'h0A
`define DEF_OVERLOAD  8'h14

// ---------------------------------------------------------------
// command results
// ---------------------------------------------------------------
`define ERR_OK        8'h00
`define ERR_INDEX     8'h01
`define ERR_VALUE     8'h02
`define ERR_NOT_ON    8'h03
`define ERR_OPCODE    8'h04
`define ERR_DENIED    8'h05

`endif

// [budget_pkg.sv]
/*
  Types shared by the port power budget manager.
  Assumes budget_regs.svh supplies the numeric constants.
*/
package budget_pkg;

  typedef enum logic [3:0] {
    OP_NONE     = 4'h0,
    OP_SYS_RST  = 4'h1,
    OP_RESTORE  = 4'h2,
    OP_PORT_CTL = 4'h3,
    OP_ADJUST   = 4'h4,
    OP_CAPACITY = 4'h5,
    OP_RESERVE  = 4'h6,
    OP_OVERLOAD = 4'h7,
    OP_GRANT_PL = 4'h8,
    OP_RETRY_PL = 4'h9,
    OP_PORT_EN  = 4'hA
  } op_t;

  typedef enum logic [1:0] {CTL_AUTO = 2'h0, CTL_FORCE_ON = 2'h1, CTL_FORCE_OFF = 2'h2} port_ctl_t;
  typedef enum logic [1:0] {PRIO_LOW = 2'h0, PRIO_HIGH = 2'h1, PRIO_FORCED = 2'h2,
                            PRIO_CRIT = 2'h3} prio_t;
  typedef enum logic {POL_GRANT = 1'b0, POL_CONSUME = 1'b1} grant_pol_t;
  typedef enum logic [1:0] {RETRY_NOW = 2'h0, RETRY_RECONNECT = 2'h1, RETRY_REENABLE = 2'h2} retry_t;
  // gray along clear -> scan -> shed -> scan
  typedef enum logic [1:0] {ST_CLEAR = 2'b00, ST_SCAN = 2'b01, ST_SHED = 2'b11} scan_st_t;

  typedef struct packed {
    logic        valid;
    logic [5:0]  port;
    logic [31:0] consumed;
    logic [31:0] requested;
  } meas_t;

endpackage

// [port_power_budget_manager.sv]
/*
  Port power budget manager: command engine, settings, per-port grant scan,
  overload shedding and retry, behind an AXI4-Lite slave.
  Assumes port controllers deliver per-port samples on meas and a detect level
  on pd_present, all synchronous to aclk.
*/
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
// How it works
// R1 - every command writes result: zero on success, nonzero error code otherwise.
// R2 - port commands accept port numbers one to forty-eight only.
// R3 - default restore loads every setting's default, then runs a system reset.
// R4 - port control codes: 0 automatic, 1 forced on, 2 forced off.
// R5 - automatic ports power on with a device attached, off when detached.
// R6 - forced-on ports get forced priority, never displace a critical port.
// R7 - a granted forced-on port turns on without any detected device.
// R8 - forced-off ports go off and stay off; temporary, unlike disabled.
// R9 - grant adjust sets a new grant, refused unless the port is on.
// R10 - each of supplies one to three holds its provided milliwatts.
// R11 - consumption policy withholds reserve percent from new requests.
// R12 - overload under the limit sheds ports one at a time.
// R13 - overload over the limit drops every low-priority port at once; the code then returns to ST_CLEAR, which turns every port off.
// R14 - granting policy codes: 0 grant-based, 1 consumption-based.
// R15 - grant-based remaining is provided minus total granted.
// R16 - consumption remaining is provided minus consumed minus reserve.
// R17 - a request is granted exactly when remaining covers it.
// R18 - a port consuming beyond its grant is overloaded and turned off.
// R19 - retry codes: 0 immediate, 1 after reconnect, 2 after re-enable.
// R20 - immediate retry powers a tripped port again at once.
// R21 - reconnect retry waits for open circuit, then reattach.
// R22 - re-enable retry disables the port; host must enable it again.
// R23 - short budget denies low-priority ports first, critical ones last.
// R24 - a disabled port never powers on; an enabled one may.
// R25 - decisions are re-evaluated continuously as inputs and settings change.
`include "budget_regs.svh"

module port_power_budget_manager
  import budget_pkg::*;
(
  // clock and reset
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  // axi4-lite slave
  input  wire logic [7:0]                   s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [7:0]                   s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  // port controllers and supplies
  input  wire meas_t                        meas,
  input  wire logic [47:0]                  pd_present,
  input  wire logic [47:0][1:0]             prio_cfg,
  input  wire logic [2:0]                   ps_present,
  output logic [47:0]                       port_power_en
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0]   awaddr_r, rd_addr;
  logic         aw_have_r, w_have_r;
  logic [31:0]  wdata_r, arg_r;
  logic [3:0]   wstrb_r;
  logic [31:0]  cap_r [3];
  logic [7:0]   reserve_r, limit_r, result_r;
  grant_pol_t   gpol_r;
  retry_t       rpol_r;
  port_ctl_t    ctl_r [48];
  logic [31:0]  granted_r [48];
  logic [31:0]  consumed_r [48];
  logic [31:0]  requested_r [48];
  logic [47:0]  on_r, en_r, blocked_r, open_seen_r;
  logic [31:0]  total_grant_r, total_cons_r;
  scan_st_t     state_r;
  logic [5:0]   ix_r, victim_r;
  logic [1:0]   level_r, victim_prio_r;
  logic         victim_ok_r;

  // ---------------------------------------------------------------
  // budget arithmetic
  // ---------------------------------------------------------------
  logic [33:0]        prov_total;
  logic signed [35:0] remain_s;
  logic [41:0]        reserve_mw, excess_x100, limit_x;
  logic               mild_ovl, severe_ovl;

  always_comb begin
    prov_total = '0;
    for (int s = 0; s < 3; s++) begin
      if (ps_present[s]) begin
        prov_total = prov_total + {2'b00, cap_r[s]};
      end
    end
    reserve_mw = (42'(prov_total) * 42'(reserve_r)) / 42'(`PCT_FULL);
    // R15 grant-based remaining
    remain_s = $signed({2'b00, prov_total}) - $signed(36'(total_grant_r));
    if (gpol_r == POL_CONSUME) begin
      // R16 R11 consumption remaining keeps the reserve out
      remain_s = $signed({2'b00, prov_total}) - $signed(36'(total_cons_r))
                 - $signed(36'(reserve_mw));
    end
    mild_ovl    = {2'b00, total_cons_r} > prov_total;
    excess_x100 = 42'({2'b00, total_cons_r} - prov_total) * 42'(`PCT_FULL);
    limit_x     = 42'(prov_total) * 42'(limit_r);
    severe_ovl  = mild_ovl && (excess_x100 > limit_x);
  end

  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  logic wr_fire, wr_ok, cmd_go;
  assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
  assign wr_ok   = (awaddr_r == `OFF_CMD) || (awaddr_r == `OFF_ARG);
  assign cmd_go  = wr_fire && (awaddr_r == `OFF_CMD);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0; w_have_r <= 1'b0; s_axi_bvalid <= 1'b0;
      s_axi_awready <= 1'b0; s_axi_wready <= 1'b0; s_axi_bresp <= 2'b00;
      awaddr_r <= '0; wdata_r <= '0; wstrb_r <= '0;
    end else begin
      s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_have_r && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        awaddr_r  <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0; aw_have_r <= 1'b0; w_have_r <= 1'b0;
      end
    end
  end

  assign rd_addr = {s_axi_araddr[7:2], 2'b00};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0; s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0; s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        unique case (rd_addr)
          `OFF_CMD:      s_axi_rdata <= wdata_r;
          `OFF_ARG:      s_axi_rdata <= arg_r;
          `OFF_RESULT:   s_axi_rdata <= {24'h0, result_r};
          `OFF_REMAIN:   s_axi_rdata <= remain_s[35] ? 32'h0 : 32'(remain_s);
          `OFF_GRANTED:  s_axi_rdata <= total_grant_r;
          `OFF_CONSUMED: s_axi_rdata <= total_cons_r;
          `OFF_PROVIDED: s_axi_rdata <= 32'(prov_total);
          `OFF_SETTINGS: s_axi_rdata <= {9'h0, gpol_r, 2'(rpol_r), 4'h0, limit_r, reserve_r};
          `OFF_ON_LO:    s_axi_rdata <= on_r[31:0];
          `OFF_ON_HI:    s_axi_rdata <= {16'h0, on_r[47:32]};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  op_t        op;
  logic [5:0] cnum, cix;
  logic [7:0] cmd_err;
  logic [32:0] adj_up;
  assign op   = op_t'(wdata_r[`CMD_OP_MSB:`CMD_OP_LSB]);
  assign cnum = wdata_r[`CMD_IX_MSB:`CMD_IX_LSB];
  assign cix  = cnum - 6'h01;
  assign adj_up = {1'b0, arg_r} - {1'b0, granted_r[cix]};

  always_comb begin
    cmd_err = `ERR_OK;
    unique case (op)
      OP_SYS_RST, OP_RESTORE: cmd_err = `ERR_OK;
      // R2 port range check first
      OP_PORT_CTL, OP_ADJUST, OP_PORT_EN: begin
        if (cnum == 6'h00 || cnum > `NUM_PORTS) begin
          cmd_err = `ERR_INDEX;
        end else if (op == OP_PORT_CTL && arg_r > 32'h2) begin
          cmd_err = `ERR_VALUE;
        end else if (op == OP_PORT_EN && arg_r > 32'h1) begin
          cmd_err = `ERR_VALUE;
        // R9 adjust only while on, rise limited by remaining
        end else if (op == OP_ADJUST && !on_r[cix]) begin
          cmd_err = `ERR_NOT_ON;
        end else if (op == OP_ADJUST && !adj_up[32] && $signed(36'(adj_up)) > remain_s) begin
          cmd_err = `ERR_DENIED;
        end
      end
      // R10 supply range
      OP_CAPACITY: cmd_err = (cnum == 6'h00 || cnum > `NUM_SUPPLIES) ? `ERR_INDEX : `ERR_OK;
      OP_RESERVE, OP_OVERLOAD: cmd_err = (arg_r > 32'(`PCT_FULL)) ? `ERR_VALUE : `ERR_OK;
      OP_GRANT_PL: cmd_err = (arg_r > 32'h1) ? `ERR_VALUE : `ERR_OK;
      OP_RETRY_PL: cmd_err = (arg_r > 32'h2) ? `ERR_VALUE : `ERR_OK;
      default: cmd_err = `ERR_OPCODE;
    endcase
  end

  logic do_cmd;
  assign do_cmd = cmd_go && (cmd_err == `ERR_OK);

  // ---------------------------------------------------------------
  // settings
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arg_r <= '0; result_r <= `ERR_OK;
    end else begin
      if (wr_fire && awaddr_r == `OFF_ARG) begin
        for (int b = 0; b < 4; b++) begin
          if (wstrb_r[b]) arg_r[8*b +: 8] <= wdata_r[8*b +: 8];
        end
      end
      // R1 result of every command
      if (cmd_go) result_r <= cmd_err;
    end
  end

  always_ff @(posedge aclk) begin
    // R3 restore loads every default
    if (!aresetn || (do_cmd && op == OP_RESTORE)) begin
      for (int s = 0; s < 3; s++) cap_r[s] <= `DEF_CAPACITY;
      reserve_r <= `DEF_RESERVE; limit_r <= `DEF_OVERLOAD;
      gpol_r <= POL_GRANT; rpol_r <= RETRY_NOW;
    end else if (do_cmd) begin
      unique case (op)
        OP_CAPACITY: cap_r[cix[1:0]] <= arg_r;
        OP_RESERVE:  reserve_r <= arg_r[7:0];
        OP_OVERLOAD: limit_r <= arg_r[7:0];
        // R14 grant policy code
        OP_GRANT_PL: gpol_r <= grant_pol_t'(arg_r[0]);
        // R19 retry policy code
        OP_RETRY_PL: rpol_r <= retry_t'(arg_r[1:0]);
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // measurement samples
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      total_cons_r <= '0;
      for (int p = 0; p < 48; p++) begin
        consumed_r[p] <= '0; requested_r[p] <= '0;
      end
    end else if (meas.valid && meas.port < `NUM_PORTS) begin
      consumed_r[meas.port]  <= meas.consumed;
      requested_r[meas.port] <= meas.requested;
      total_cons_r <= total_cons_r - consumed_r[meas.port] + meas.consumed;
    end
  end

  // ---------------------------------------------------------------
  // per-port scan
  // ---------------------------------------------------------------
  prio_t      cur_prio;
  logic       cur_want, cur_drop, cur_trip, cur_fit;
  logic [31:0] cur_req;
  always_comb begin
    // R6 forced ports rise to forced unless critical
    cur_prio = prio_t'(prio_cfg[ix_r]);
    if (ctl_r[ix_r] != CTL_AUTO && cur_prio != PRIO_CRIT) cur_prio = PRIO_FORCED;
    // R24 R5 R7 who wants power
    cur_want = en_r[ix_r] && !blocked_r[ix_r] &&
               (ctl_r[ix_r] == CTL_FORCE_ON || (ctl_r[ix_r] == CTL_AUTO && pd_present[ix_r]));
    cur_drop = !cur_want;
    cur_trip = consumed_r[ix_r] > granted_r[ix_r];
    cur_req  = requested_r[ix_r];
    cur_fit  = remain_s >= $signed(36'(cur_req));
  end

  logic scan_vis;
  assign scan_vis = (state_r == ST_SCAN) && !cmd_go;

  always_ff @(posedge aclk) begin
    // R3 restore ends in a full system reset
    if (!aresetn || (do_cmd && (op == OP_SYS_RST || op == OP_RESTORE))) begin
      state_r <= ST_CLEAR;
      // cleared here too, so no unknown reaches port_power_en after reset
      on_r    <= '0;
      if (!aresetn || op == OP_RESTORE) begin
        en_r <= '1;
        for (int p = 0; p < 48; p++) ctl_r[p] <= CTL_AUTO;
      end
    end else if (do_cmd) begin
      unique case (op)
        // R4 control code stored per port
        OP_PORT_CTL: ctl_r[cix] <= port_ctl_t'(arg_r[1:0]);
        OP_PORT_EN: begin
          en_r[cix] <= arg_r[0];
          blocked_r[cix] <= 1'b0;
        end
        OP_ADJUST: begin
          granted_r[cix] <= arg_r;
          total_grant_r  <= total_grant_r - granted_r[cix] + arg_r;
        end
        default: ;
      endcase
    // a refused command pauses the scan as well, so only a system reset or restore command cycle moves power
    end else if (!cmd_go) begin
      unique case (state_r)
        ST_CLEAR: begin
          on_r <= '0; blocked_r <= '0; open_seen_r <= '0; total_grant_r <= '0;
          for (int p = 0; p < 48; p++) granted_r[p] <= '0;
          ix_r <= '0; level_r <= `PRIO_TOP; victim_ok_r <= 1'b0;
          state_r <= ST_SCAN;
        end
        ST_SCAN: begin
          // R21 open circuit then reattach releases the block
          if (blocked_r[ix_r] && !pd_present[ix_r]) open_seen_r[ix_r] <= 1'b1;
          if (blocked_r[ix_r] && open_seen_r[ix_r] && pd_present[ix_r]) blocked_r[ix_r] <= 1'b0;
          if (on_r[ix_r]) begin
            // R8 forced off or detached ports drop at once
            if (cur_drop || cur_trip) begin
              on_r[ix_r] <= 1'b0;
              granted_r[ix_r] <= '0;
              total_grant_r <= total_grant_r - granted_r[ix_r];
            end
            // R18 overload trip
            if (!cur_drop && cur_trip) begin
              // R21 reconnect waits for an open circuit
              if (rpol_r == RETRY_RECONNECT) begin
                blocked_r[ix_r] <= 1'b1;
                open_seen_r[ix_r] <= 1'b0;
              end
              // R22 re-enable policy disables the port
              if (rpol_r == RETRY_REENABLE) en_r[ix_r] <= 1'b0;
            end
            if (!cur_drop && !cur_trip && (!victim_ok_r || 2'(cur_prio) < victim_prio_r)) begin
              victim_ok_r <= 1'b1; victim_r <= ix_r; victim_prio_r <= 2'(cur_prio);
            end
          // R23 R17 R20 grant per level, highest level first
          end else if (cur_want && 2'(cur_prio) == level_r && cur_fit) begin
            on_r[ix_r] <= 1'b1;
            granted_r[ix_r] <= cur_req;
            total_grant_r <= total_grant_r + cur_req;
          end
          if (ix_r == `NUM_PORTS - 6'h01) begin
            ix_r <= '0;
            level_r <= level_r - 2'h1;
            if (level_r == 2'h0) state_r <= ST_SHED;
          end else begin
            ix_r <= ix_r + 6'h01;
          end
        end
        ST_SHED: begin
          // R13 severe overload drops all low ports together
          if (severe_ovl) begin
            for (int p = 0; p < 48; p++) begin
              if (prio_cfg[p] == 2'(PRIO_LOW) && ctl_r[p] == CTL_AUTO) begin
                on_r[p] <= 1'b0;
                granted_r[p] <= '0;
              end
            end
            state_r <= ST_CLEAR;
          // R12 mild overload sheds one lowest-priority port per pass
          end else if (mild_ovl && victim_ok_r) begin
            on_r[victim_r] <= 1'b0;
            granted_r[victim_r] <= '0;
            total_grant_r <= total_grant_r - granted_r[victim_r];
          end
          victim_ok_r <= 1'b0;
          if (!severe_ovl) state_r <= ST_SCAN;
        end
        default: state_r <= ST_CLEAR;
      endcase
    end
  end

  // R25 output follows the rolling scan
  always_ff @(posedge aclk) begin
    if (!aresetn) port_power_en <= '0;
    else port_power_en <= on_r;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_port_range: assert property (@(posedge aclk) disable iff (!aresetn) // R2
    cmd_go && op == OP_PORT_CTL && (cnum == 6'h00 || cnum > `NUM_PORTS)
    |=> result_r == `ERR_INDEX && $stable(on_r)) else $error("bad port index accepted");
  a_adjust_off: assert property (@(posedge aclk) disable iff (!aresetn) // R9
    cmd_go && op == OP_ADJUST && cnum != 6'h00 && cnum <= `NUM_PORTS && !on_r[cix]
    |=> result_r == `ERR_NOT_ON) else $error("adjust on off port accepted");
  a_force_off: assert property (@(posedge aclk) disable iff (!aresetn) // R8
    scan_vis && ctl_r[ix_r] == CTL_FORCE_OFF |=> !on_r[$past(ix_r)])
    else $error("forced off port left on");
  a_trip_off: assert property (@(posedge aclk) disable iff (!aresetn) // R18
    scan_vis && on_r[ix_r] && cur_trip |=> !on_r[$past(ix_r)] ##1 !port_power_en[$past(ix_r, 2)])
    else $error("overloaded port kept on");
  a_reenable_off: assert property (@(posedge aclk) disable iff (!aresetn) // R22
    scan_vis && on_r[ix_r] && cur_trip && !cur_drop && rpol_r == RETRY_REENABLE
    |=> !en_r[$past(ix_r)]) else $error("tripped port not disabled");
  a_no_fit: assert property (@(posedge aclk) disable iff (!aresetn) // R17
    scan_vis && !on_r[ix_r] && !cur_fit |=> !on_r[$past(ix_r)])
    else $error("port granted beyond remaining budget");
  a_severe_low: assert property (@(posedge aclk) disable iff (!aresetn) // R13
    state_r == ST_SHED && severe_ovl && !cmd_go |=> state_r == ST_CLEAR ##1 on_r == 48'h0)
    else $error("low ports not dropped on severe overload");
  a_restore_reset: assert property (@(posedge aclk) disable iff (!aresetn) // R3
    cmd_go && op == OP_RESTORE |=> reserve_r == `DEF_RESERVE && state_r == ST_CLEAR
    && result_r == `ERR_OK) else $error("restore did not default and reset");

endmodule

// [host_model.sv]
/*
  Host side model: AXI4-Lite master tasks for the budget manager.
  Assumes each task is entered just after a rising edge of aclk.
*/
module host_model (
  // clock
  input  wire logic        aclk,
  // write channels
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  // read channels
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  int hangs = 0;
  initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid,
           s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  // trailing idle edge keeps a release and the next raise apart
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    r = 2'h3;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 200) hangs++;
    else r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    {d, r} = '1;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 200) hangs++;
    else {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
endmodule

// [testbench.sv]
/*
  Self-checking bench of the budget manager: command table, then grant,
  bus refusal and restore cases. Assumes host_model drives the register bus.
*/
`include "budget_regs.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module testbench import budget_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [31:0] cmd; logic [31:0] arg; logic [7:0] res;} row_t;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  meas_t meas = '0;
  logic [47:0] pd_present = '0, port_power_en;
  logic [47:0][1:0] prio_cfg = '0;
  logic [2:0] ps_present = 3'h7;
  int num_errors = 0, checks = 0;
  row_t rows [10] = '{'{32'h6, 32'h65, `ERR_VALUE}, '{32'h3, 32'h0, `ERR_INDEX},
    '{32'h3103, 32'h0, `ERR_INDEX}, '{32'h405, 32'h0, `ERR_INDEX}, '{32'h103, 32'h3, `ERR_VALUE},
    '{32'h8, 32'h2, `ERR_VALUE}, '{32'h9, 32'h3, `ERR_VALUE}, '{32'h104, 32'h5, `ERR_NOT_ON},
    '{32'hF, 32'h0, `ERR_OPCODE}, '{32'h105, 32'h3E8, `ERR_OK}};
  always #4 aclk = ~aclk;
  // a bus wait that ran out ends the run at once
  always @(posedge aclk) if (host.hangs != 0) conclude;
  port_power_budget_manager dut (.*);
  host_model host (.*);
  task automatic conclude;
    num_errors += host.hangs;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cmd(input logic [31:0] c, input logic [31:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    host.wr(`OFF_ARG, a, r);
    host.wr(`OFF_CMD, c, r);
    host.rd(`OFF_RESULT, d, r);
    `CHK("result", e, d[7:0])
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    host.rd(a, d, r);
    `CHK("register", e, d)
  endtask
  task automatic wait_en(input int p, input logic v);
    for (int n = 0; n < 500 && port_power_en[p] !== v; n++) @(posedge aclk);
    `CHK("port_power_en", v, port_power_en[p])
    if (port_power_en[p] !== v) conclude;
  endtask
  task automatic ask(input logic [5:0] p, input logic [31:0] c, input logic [31:0] mw);
    pd_present[p] <= 1'b1;
    meas <= '{1'b1, p, c, mw};
    @(posedge aclk);
    meas.valid <= 1'b0;
  endtask
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdchk(`OFF_SETTINGS, 32'h0000_140A);
    `CHK("power after reset", 48'h0, port_power_en)
    $display("test reset done");
    foreach (rows[i]) cmd(rows[i].cmd, rows[i].arg, rows[i].res);
    $display("test table done");
    ask(6'h00, 32'h0, 32'h3E8);
    wait_en(0, 1'b1);
    rdchk(`OFF_GRANTED, 32'h3E8);
    rdchk(`OFF_REMAIN, 32'h0);
    ask(6'h01, 32'h0, 32'h1);
    repeat (400) @(posedge aclk);
    `CHK("denied port", 1'b0, port_power_en[1])
    cmd(32'h104, 32'h1F4, `ERR_OK);
    wait_en(1, 1'b1);
    rdchk(`OFF_GRANTED, 32'h1F5);
    cmd(32'h103, 32'h2, `ERR_OK);
    wait_en(0, 1'b0);
    cmd(32'h104, 32'h64, `ERR_NOT_ON);
    $display("test grant done");
    cmd(32'h9, 32'h2, `ERR_OK);
    ask(6'h01, 32'h1388, 32'h1);
    wait_en(1, 1'b0);
    ask(6'h01, 32'h0, 32'h1);
    repeat (400) @(posedge aclk);
    `CHK("disabled port", 1'b0, port_power_en[1])
    cmd(32'h20A, 32'h1, `ERR_OK);
    wait_en(1, 1'b1);
    $display("test overload done");
    host.wr(8'h40, 32'h1, r);
    `CHK("bresp", 2'h2, r)
    host.rd(8'h3C, d, r);
    `CHK("rresp", 2'h2, r)
    $display("test bus done");
    cmd(32'h2, 32'h0, `ERR_OK);
    rdchk(`OFF_PROVIDED, 32'h0);
    rdchk(`OFF_SETTINGS, 32'h0000_140A);
    $display("test restore done");
    conclude;
  end
endmodule
